// ### hw/toss_sequencer.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Operation
// - The state index drives the contacts: 0 both open, 1 first only, 2 second only, 3 both.
// - In the fixed variant and in full cycle mode each press steps 0,1,2,3 and wraps to 0.
// - In short cycle mode each press steps 0,1,2 and wraps to 0, never entering 3.
// - In timed full mode a press within 5 s of the last one cycles among 1, 2 and 3.
// - In timed short mode a press within 5 s of the last one alternates between 1 and 2.
// - In both timed modes a press in a nonzero state more than 5 s after the last one forces state 0.
// - In both timed modes a long press in any state forces state 0.
// - In both timed modes a press after switch-off restores the stored nonzero state, a stored 3 as 2 in timed short mode.
// - The stored state is cleared by reset, so nothing is remembered after power returns.
module toss_sequencer #(
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'(toss_pkg::DEBOUNCE_CYC),
    parameter logic [31:0] LONG_PRESS_CYCLES = 32'(toss_pkg::LONG_PRESS_CYC),
    parameter logic [31:0] IDLE_TIMEOUT_CYCLES = 32'(toss_pkg::IDLE_TIMEOUT_CYC)
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Push-button, high while pressed
    input wire logic button_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Contact drivers
    output logic first_contact_output_out,
    output logic second_contact_output_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    logic deb_q;
    logic deb_d;
    logic [31:0] deb_cnt_q;
    logic [31:0] deb_cnt_d;

    toss_pkg::toss_press_state_type prs_q;
    toss_pkg::toss_press_state_type prs_d;
    logic [31:0] hold_cnt_q;
    logic [31:0] hold_cnt_d;
    toss_pkg::toss_press_type btn_evt;

    logic window_q;
    logic window_d;
    logic [31:0] idle_cnt_q;
    logic [31:0] idle_cnt_d;

    logic [1:0] state_q;
    logic [1:0] state_d;
    logic [1:0] mem_q;
    logic [1:0] mem_d;
    logic [15:0] presses_q;
    logic [15:0] presses_d;

    toss_pkg::toss_ctrl_type ctrl_q;
    toss_pkg::toss_ctrl_type ctrl_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    logic wr_en;
    logic soft_press;
    logic forget;
    logic any_press;
    logic short_evt;
    logic long_evt;
    logic timed;
    logic short_cycle;
    logic addr_hit;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // ------------------------------------------------------------
    // Button synchroniser and debouncer
    // ------------------------------------------------------------
    // Level must stay changed for a full debounce time before it counts
    always_comb begin
        deb_d = deb_q;
        deb_cnt_d = 32'h0000_0000;
        if (sync2_q != deb_q) begin
            deb_cnt_d = deb_cnt_q + 32'h0000_0001;
            if (deb_cnt_d >= DEBOUNCE_CYCLES) begin
                deb_d = sync2_q;
                deb_cnt_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            deb_q <= 1'b0;
            deb_cnt_q <= 32'h0000_0000;
        end else begin
            sync1_q <= button_in;
            sync2_q <= sync1_q;
            deb_q <= deb_d;
            deb_cnt_q <= deb_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Press classifier
    // ------------------------------------------------------------
    // Short press fires on release; long press fires once while still held
    always_comb begin
        prs_d = prs_q;
        hold_cnt_d = hold_cnt_q;
        btn_evt = '{short_press: 1'b0, long_press: 1'b0};
        case (prs_q)
            toss_pkg::TOSS_PRS_IDLE: begin
                hold_cnt_d = 32'h0000_0000;
                if (deb_q) begin
                    prs_d = toss_pkg::TOSS_PRS_HELD;
                end
            end
            toss_pkg::TOSS_PRS_HELD: begin
                if (!deb_q) begin
                    btn_evt.short_press = 1'b1;
                    prs_d = toss_pkg::TOSS_PRS_IDLE;
                end else begin
                    hold_cnt_d = hold_cnt_q + 32'h0000_0001;
                    if (hold_cnt_d >= LONG_PRESS_CYCLES) begin
                        btn_evt.long_press = 1'b1;
                        prs_d = toss_pkg::TOSS_PRS_LONG;
                    end
                end
            end
            toss_pkg::TOSS_PRS_LONG: begin
                if (!deb_q) begin
                    prs_d = toss_pkg::TOSS_PRS_IDLE;
                end
            end
            default: begin
                prs_d = toss_pkg::TOSS_PRS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prs_q <= toss_pkg::TOSS_PRS_IDLE;
            hold_cnt_q <= 32'h0000_0000;
        end else begin
            prs_q <= prs_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Inactivity window
    // ------------------------------------------------------------
    assign short_evt = btn_evt.short_press | soft_press;
    assign long_evt = btn_evt.long_press;
    assign any_press = short_evt | long_evt;

    // Window closed after reset: the first press has no predecessor
    always_comb begin
        window_d = window_q;
        idle_cnt_d = idle_cnt_q;
        if (any_press) begin
            window_d = 1'b1;
            idle_cnt_d = 32'h0000_0000;
        end else if (window_q) begin
            idle_cnt_d = idle_cnt_q + 32'h0000_0001;
            if (idle_cnt_d >= IDLE_TIMEOUT_CYCLES) begin
                window_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            window_q <= 1'b0;
            idle_cnt_q <= 32'h0000_0000;
        end else begin
            window_q <= window_d;
            idle_cnt_q <= idle_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign timed = !ctrl_q.fixed && (ctrl_q.mode == toss_pkg::TOSS_MODE_TIMED_FULL
        || ctrl_q.mode == toss_pkg::TOSS_MODE_TIMED_SHORT);
    assign short_cycle = !ctrl_q.fixed && (ctrl_q.mode == toss_pkg::TOSS_MODE_SHORT
        || ctrl_q.mode == toss_pkg::TOSS_MODE_TIMED_SHORT);

    always_comb begin
        state_d = state_q;
        mem_d = mem_q;
        presses_d = presses_q;
        if (any_press) begin
            presses_d = presses_q + 16'h0001;
        end
        if (forget) begin
            mem_d = toss_pkg::MEM_RST;
        end
        if (!timed) begin
            // Long press simply counts as one more step here
            if (any_press) begin
                if (short_cycle) begin
                    state_d = (state_q >= 2'h2) ? 2'h0 : state_q + 2'h1;
                end else begin
                    state_d = state_q + 2'h1;
                end
            end
        end else if (long_evt) begin
            state_d = 2'h0;
            if (state_q != 2'h0) begin
                mem_d = state_q;
            end
        end else if (short_evt) begin
            if (state_q == 2'h0) begin
                // Nothing stored yet: start from the first step
                state_d = (mem_d != 2'h0) ? mem_d : 2'h1;
                if (short_cycle && state_d == 2'h3) begin
                    state_d = 2'h2;
                end
            end else if (!window_q) begin
                state_d = 2'h0;
                mem_d = state_q;
            end else if (short_cycle) begin
                state_d = (state_q == 2'h1) ? 2'h2 : 2'h1;
            end else begin
                state_d = (state_q == 2'h3) ? 2'h1 : state_q + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= toss_pkg::STATE_RST;
            mem_q <= toss_pkg::MEM_RST;
            presses_q <= toss_pkg::PRESSES_RST;
        end else begin
            state_q <= state_d;
            mem_q <= mem_d;
            presses_q <= presses_d;
        end
    end

    assign first_contact_output_out = state_q[0];
    assign second_contact_output_out = state_q[1];

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    // Read data is captured in the setup cycle so it leaves a flip-flop
    assign addr_hit = (paddr_in == toss_pkg::ADDR_CTRL) || (paddr_in == toss_pkg::ADDR_STATUS)
        || (paddr_in == toss_pkg::ADDR_PRESSES);
    assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0]
        && (paddr_in == toss_pkg::ADDR_CTRL);
    assign soft_press = wr_en && pwdata_in[toss_pkg::CTRL_SOFT_PRESS_BIT];
    assign forget = wr_en && pwdata_in[toss_pkg::CTRL_FORGET_BIT];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[toss_pkg::STAT_STATE_LSB +: 2] = state_q;
        status_word[toss_pkg::STAT_MEM_LSB +: 2] = mem_q;
        status_word[toss_pkg::STAT_WINDOW_BIT] = window_q;
        status_word[toss_pkg::STAT_HELD_BIT] = deb_q;
        status_word[toss_pkg::STAT_LONG_BIT] = (prs_q == toss_pkg::TOSS_PRS_LONG);
        rd_word = 32'h0000_0000;
        case (paddr_in)
            toss_pkg::ADDR_CTRL: begin
                rd_word[toss_pkg::CTRL_MODE_LSB +: 2] = ctrl_q.mode;
                rd_word[toss_pkg::CTRL_FIXED_BIT] = ctrl_q.fixed;
            end
            toss_pkg::ADDR_STATUS: begin
                rd_word = status_word;
            end
            toss_pkg::ADDR_PRESSES: begin
                rd_word[15:0] = presses_q;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (psel_in && !penable_in) begin
            prdata_d = pwrite_in ? 32'h0000_0000 : rd_word;
            pslverr_d = !addr_hit;
        end
        if (wr_en) begin
            ctrl_d.mode = toss_pkg::toss_mode_type'(pwdata_in[toss_pkg::CTRL_MODE_LSB +: 2]);
            ctrl_d.fixed = pwdata_in[toss_pkg::CTRL_FIXED_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= toss_pkg::CTRL_RST;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign pready_out = psel_in && penable_in;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q && pready_out;

endmodule : toss_sequencer

// ### hw/toss_pkg.sv
package toss_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned IDLE_TIMEOUT_S = 5;
    localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned LONG_PRESS_MS = 1000;
    localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_PRESSES = 32'h0000_0008;

    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_FIXED_BIT = 2;
    localparam int unsigned CTRL_FORGET_BIT = 3;
    localparam int unsigned CTRL_SOFT_PRESS_BIT = 4;

    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_MEM_LSB = 2;
    localparam int unsigned STAT_WINDOW_BIT = 4;
    localparam int unsigned STAT_HELD_BIT = 5;
    localparam int unsigned STAT_LONG_BIT = 6;

    localparam logic [1:0] STATE_RST = 2'h0;
    localparam logic [1:0] MEM_RST = 2'h0;
    localparam logic [15:0] PRESSES_RST = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TOSS_MODE_FULL = 2'h0,
        TOSS_MODE_SHORT = 2'h1,
        TOSS_MODE_TIMED_FULL = 2'h2,
        TOSS_MODE_TIMED_SHORT = 2'h3
    } toss_mode_type;

    typedef enum logic [2:0] {
        TOSS_PRS_IDLE = 3'h1,
        TOSS_PRS_HELD = 3'h2,
        TOSS_PRS_LONG = 3'h4
    } toss_press_state_type;

    typedef struct packed {
        logic fixed;
        toss_mode_type mode;
    } toss_ctrl_type;

    localparam toss_ctrl_type CTRL_RST = '{fixed: 1'b0, mode: TOSS_MODE_FULL};

    typedef struct packed {
        logic short_press;
        logic long_press;
    } toss_press_type;

endpackage : toss_pkg

// ### verification/toss_seq_properties.sv
`timescale 1ns/1ps
module toss_seq_properties #(
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'h4
) (
    // Clock, reset, button
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic button_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Contacts
    input wire logic first_contact_output_out,
    input wire logic second_contact_output_out
);
    // ----
    // Shadow of mode and idle time
    // ----
    logic [1:0] st;
    logic [1:0] mode_q, mode_d;
    logic fixed_q, fixed_d, hit, plain, tfull, tshort;
    logic [31:0] quiet_q, quiet_d;
    assign st = {second_contact_output_out, first_contact_output_out};
    assign hit = paddr_in == toss_pkg::ADDR_CTRL || paddr_in == toss_pkg::ADDR_STATUS
        || paddr_in == toss_pkg::ADDR_PRESSES;
    assign plain = fixed_q || mode_q == toss_pkg::TOSS_MODE_FULL;
    assign tfull = !fixed_q && mode_q == toss_pkg::TOSS_MODE_TIMED_FULL;
    assign tshort = !fixed_q && mode_q == toss_pkg::TOSS_MODE_TIMED_SHORT;
    always_comb begin
        mode_d = mode_q;
        fixed_d = fixed_q;
        if (psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == toss_pkg::ADDR_CTRL) begin
            mode_d = pwdata_in[1:0];
            fixed_d = pwdata_in[toss_pkg::CTRL_FIXED_BIT];
        end
        // Any bus access or held button may legitimately move the contacts
        quiet_d = (button_in || psel_in) ? 32'h0 : quiet_q + 32'(quiet_q != 32'hFFFF_FFFF);
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= 2'h0;
            fixed_q <= 1'b0;
            quiet_q <= 32'h0;
        end else begin
            mode_q <= mode_d;
            fixed_q <= fixed_d;
            quiet_q <= quiet_d;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    reset_open_a: assert property (disable iff (1'b0) !rst_n_in |-> st == 2'h0)
        else $error("contacts closed during reset");
    pready_zero_a: assert property (pready_out == (psel_in && penable_in))
        else $error("pready not tied to access phase");
    unmapped_err_a: assert property (psel_in && penable_in && !pwrite_in && !hit
        |-> pslverr_out && prdata_out == 32'h0) else $error("unmapped read not refused");
    err_place_a: assert property (pslverr_out |-> pready_out && !hit)
        else $error("error outside unmapped access");
    quiet_hold_a: assert property (quiet_q > DEBOUNCE_CYCLES + 32'h8 |-> $stable(st))
        else $error("contacts moved without a press");
    full_step_a: assert property (plain && $changed(st) |-> st == $past(st) + 2'h1)
        else $error("full cycle step wrong");
    short_step_a: assert property (!fixed_q && mode_q == toss_pkg::TOSS_MODE_SHORT && $changed(st)
        |-> st == ($past(st) == 2'h2 ? 2'h0 : $past(st) + 2'h1)) else $error("short cycle step wrong");
    tfull_step_a: assert property (tfull && $changed(st) && $past(st) != 2'h0
        |-> st == 2'h0 || st == ($past(st) == 2'h3 ? 2'h1 : $past(st) + 2'h1))
        else $error("timed full step wrong");
    tshort_step_a: assert property (tshort && $changed(st) && $past(st) != 2'h0
        |-> st == 2'h0 || st == ($past(st) == 2'h1 ? 2'h2 : 2'h1)) else $error("timed short step wrong");
endmodule : toss_seq_properties

bind toss_sequencer toss_seq_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .button_in(button_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .first_contact_output_out(first_contact_output_out),
    .second_contact_output_out(second_contact_output_out));

// ### verification/toss_button_model.sv
`timescale 1ns/1ps
module toss_button_model (
    // Clock
    input wire logic ref_clk_in,
    // Contact, high while held; pulled low when released
    output logic button_out
);
    initial button_out = 1'b0;
    // Single-cycle chatter on make and break, shorter than any sane debounce
    task automatic press(input int hold_cyc);
        int i;
        for (i = 0; i < 5; i++) begin
            @(posedge ref_clk_in);
            button_out <= ~i[0];
        end
        repeat (hold_cyc) @(posedge ref_clk_in);
        for (i = 0; i < 5; i++) begin
            @(posedge ref_clk_in);
            button_out <= i[0];
        end
        repeat (16) @(posedge ref_clk_in);
    endtask : press
endmodule : toss_button_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_n_in;
    logic button_in;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, prdata_out, rd;
    logic [3:0] pstrb_in = 4'hF;
    logic pready_out, pslverr_out, er, first_contact_output_out, second_contact_output_out;
    int fails = 0;
    int compares = 0;
    int i;
    always #25 ref_clk_in = ~ref_clk_in;
    toss_button_model btn (.ref_clk_in(ref_clk_in), .button_out(button_in));
    // Short counts keep the run brief
    toss_sequencer #(.DEBOUNCE_CYCLES(32'h4), .LONG_PRESS_CYCLES(32'h28),
        .IDLE_TIMEOUT_CYCLES(32'h64)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .button_in(button_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .first_contact_output_out(first_contact_output_out),
        .second_contact_output_out(second_contact_output_out));
    // ----
    // Tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        // No wait-state count assumed; the watchdog ends a hang
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task automatic push(input int hold_cyc, input logic [1:0] exp);
        btn.press(hold_cyc);
        check({30'h0, second_contact_output_out, first_contact_output_out}, {30'h0, exp});
    endtask : push
    task automatic finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        fails++;
        finish_test();
    end
    // ----
    // Tests
    // ----
    initial begin
        // Driven at time zero so the asynchronous reset sees an edge
        rst_n_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rdchk(toss_pkg::ADDR_CTRL, 32'h0);
        rdchk(toss_pkg::ADDR_PRESSES, 32'h0);
        apb(1'b1, toss_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rdchk(toss_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, 32'h0000_000C, 32'h0);
        check({rd[31:1], er}, 32'h1);
        $display("test registers done");
        for (i = 1; i < 5; i++) push(10, 2'(i));
        rdchk(toss_pkg::ADDR_PRESSES, 32'h4);
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'h6);
        push(10, 2'h1);
        repeat (150) @(posedge ref_clk_in);
        push(10, 2'h2);
        push(60, 2'h3);
        push(10, 2'h0);
        $display("test full cycle done");
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'h1);
        for (i = 1; i < 4; i++) push(10, 2'(i % 3));
        $display("test short cycle done");
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'hA);
        push(10, 2'h1);
        push(10, 2'h2);
        push(10, 2'h3);
        push(10, 2'h1);
        push(10, 2'h2);
        push(60, 2'h0);
        push(10, 2'h2);
        repeat (150) @(posedge ref_clk_in);
        push(10, 2'h0);
        push(10, 2'h2);
        $display("test timed full done");
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'h3);
        push(10, 2'h1);
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'h13);
        repeat (2) @(posedge ref_clk_in);
        check({30'h0, second_contact_output_out, first_contact_output_out}, 32'h2);
        push(60, 2'h0);
        push(10, 2'h2);
        push(60, 2'h0);
        // Forget drops the stored 2, so the next press starts from the first step
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'hB);
        push(10, 2'h1);
        push(10, 2'h2);
        push(60, 2'h0);
        $display("test timed short done");
        // Stored state is 2 here; a reset must lose it
        rst_n_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        apb(1'b1, toss_pkg::ADDR_CTRL, 32'h2);
        push(10, 2'h1);
        $display("test reset memory done");
        finish_test();
    end
endmodule : tb_top
